// ---- core/psc_pkg.sv ----
// Shared constants and types for the pressure sensor configuration link
// Behaviour
// - Range limits stay in calibrated unit always
// - Scale factor at 83 multiplies reading
// - Unit code in bits 7..0 of 84
// - Relative mode subtracts stored offset
// - Offset at 87, host writable
// - Status bit 11 captures reading as offset
// - Status bit 12 enables relative mode
// - Auto-mode request during acquisition sets overrun
// - Averaging exponents at 82, bytes 1 and 0
// - Delivered exponents: pressure 2, temperature 1
// - Acquisition 2.12ms times exponent powers plus 10.60ms; code uses 2.12us and 10.60us
// - Manual request time excluded from estimate
// - Status bit 9 interleave, exponents zero first
// - Interleave acquisition typically 10 ms; code uses a fixed 10 us
// - Span trim 68, zero trim 69, read/write
// - Host computes new trims from measured slope
// - Recalibration points below 10%, above 90%
// - Date at 72: year, month, day
// - Key 4118 unlocks, zero relocks
// - Status bit 5 saves configuration
// - Configuration writes take effect immediately
package psc_pkg;
    localparam logic [6:0] REG_STATUS = 7'h00;
    localparam logic [6:0] REG_COMP = 7'h01;
    localparam logic [6:0] REG_ACCESS = 7'h05;
    localparam logic [6:0] REG_MAX = 7'h40;
    localparam logic [6:0] REG_MIN = 7'h41;
    localparam logic [6:0] REG_SPAN = 7'h44;
    localparam logic [6:0] REG_ZERO = 7'h45;
    localparam logic [6:0] REG_DATE = 7'h48;
    localparam logic [6:0] REG_AVG = 7'h52;
    localparam logic [6:0] REG_SCALE = 7'h53;
    localparam logic [6:0] REG_UNIT = 7'h54;
    localparam logic [6:0] REG_TARE = 7'h57;
    localparam int B_CONV = 0;
    localparam int B_WENB = 3;
    localparam int B_SAVE = 5;
    localparam int B_AUTO = 8;
    localparam int B_INTL = 9;
    localparam int B_OVERRUN = 10;
    localparam int B_SETTARE = 11;
    localparam int B_TARE = 12;
    localparam logic [31:0] ACCESS_KEY = 32'h0000_1016;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] AVG_RESET = 32'h0000_0201;
    localparam logic [31:0] SCALE_RESET = 32'h0001_0000;
    localparam logic [31:0] UNIT_RESET = 32'h0000_0002;
    localparam logic [31:0] SPAN_RESET = 32'h0001_0000;
    localparam int SCALE_FRAC = 16;
    localparam int CLK_HZ = 25_000_000;
    localparam int STEP_NS = 2120;
    localparam int BASE_NS = 10600;
    localparam int INTL_NS = 10000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int STEP_CYC = STEP_NS / CLK_NS;
    localparam int BASE_CYC = BASE_NS / CLK_NS;
    localparam int INTL_CYC = INTL_NS / CLK_NS;
    localparam logic [7:0] EXP_MAX = 8'h10;
    localparam logic [31:0] ONE32 = 32'h0000_0001;
    // Host command codes
    typedef enum logic [1:0] {
        psc_cmd_idle_t_v,
        psc_cmd_write,
        psc_cmd_read
    } psc_cmd_t;
endpackage : psc_pkg

// ---- core/psc_if.sv ----
// Register access link between sensor register set and host
interface psc_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic req;
    logic wr;
    logic [6:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    modport dev (input pclk, presetn, req, wr, addr, wdata,
        output ack, rdata);
    modport host (input pclk, presetn, ack, rdata,
        output req, wr, addr, wdata);
endinterface : psc_if

// ---- core/psc_sensor_regs.sv ----
// Sensor-side configuration register set with acquisition timing
module psc_sensor_regs
    import psc_pkg::*;
(
    // Link
    psc_if.dev lnk,
    // Measurement side
    input wire logic [31:0] raw_pressure,
    input wire logic [31:0] range_max,
    input wire logic [31:0] range_min,
    input wire logic acq_tick,
    output logic [31:0] compensated_pressure,
    output logic acquiring,
    output logic nvm_save,
    output logic [31:0] span_trim,
    output logic [31:0] zero_trim
);
    typedef struct packed {
        logic [31:0] status;
        logic unlocked;
        logic [31:0] span;
        logic [31:0] zero;
        logic [31:0] date;
        logic [31:0] avg;
        logic [31:0] scale;
        logic [31:0] unit;
        logic [31:0] tare;
        logic [31:0] comp;
        logic [31:0] cnt;
        logic busy;
        logic save;
        logic ack;
        logic [31:0] rdata;
    } psc_dev_st_t;

    psc_dev_st_t st_ff;
    psc_dev_st_t nxt_st;

    function automatic logic [31:0] pow2(input logic [7:0] e);
        logic [7:0] c;
        c = (e > EXP_MAX) ? EXP_MAX : e;
        pow2 = ONE32 << c;
    endfunction : pow2

    function automatic logic [31:0] acq_cycles(input logic [31:0] a,
        input logic intl);
        logic [31:0] s;
        s = pow2(a[15:8]) + pow2(a[7:0]);
        if (intl) begin
            acq_cycles = 32'(INTL_CYC);
        end else begin
            acq_cycles = 32'(s * 32'(STEP_CYC)) + 32'(BASE_CYC);
        end
    endfunction : acq_cycles

    logic [63:0] scaled;
    logic [31:0] rel;
    logic wr_cfg;
    logic acq_done;
    logic ovr_set;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.save = 1'b0;
        wr_cfg = lnk.req && lnk.wr && st_ff.unlocked;
        acq_done = st_ff.busy && (st_ff.cnt <= ONE32);
        ovr_set = st_ff.status[B_AUTO] && acq_tick && st_ff.busy;
        // Relative value and scaling
        rel = st_ff.status[B_TARE] ? raw_pressure - st_ff.tare
            : raw_pressure;
        scaled = 64'(rel) * 64'(st_ff.scale);
        // Acquisition timing; manual time counted from request taken
        if (st_ff.busy) begin
            if (acq_done) begin
                nxt_st.busy = 1'b0;
                nxt_st.comp = scaled[SCALE_FRAC+31:SCALE_FRAC];
                nxt_st.status[B_CONV] = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt - ONE32;
            end
        end
        // Auto-update request
        if (st_ff.status[B_AUTO] && acq_tick) begin
            if (ovr_set) begin
                nxt_st.status[B_OVERRUN] = 1'b1;
            end else begin
                nxt_st.busy = 1'b1;
                nxt_st.cnt = acq_cycles(st_ff.avg, st_ff.status[B_INTL]);
            end
        end

        // Host register access
        if (lnk.req && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = ZERO32;
            if (lnk.wr) begin
                case (lnk.addr)
                    REG_ACCESS: begin
                        nxt_st.unlocked = (lnk.wdata == ACCESS_KEY);
                    end
                    REG_STATUS: begin
                        if (lnk.wdata[B_CONV] && !st_ff.busy) begin
                            nxt_st.status[B_CONV] = 1'b0;
                            nxt_st.busy = 1'b1;
                            nxt_st.cnt = acq_cycles(st_ff.avg,
                                lnk.wdata[B_INTL]);
                        end
                        nxt_st.status[B_AUTO] = lnk.wdata[B_AUTO];
                        nxt_st.status[B_INTL] = lnk.wdata[B_INTL];
                        nxt_st.status[B_TARE] = lnk.wdata[B_TARE];
                        // Overrun set wins over a clear in one cycle
                        if (!lnk.wdata[B_OVERRUN] && !ovr_set) begin
                            nxt_st.status[B_OVERRUN] = 1'b0;
                        end
                        if (lnk.wdata[B_SETTARE]) begin
                            nxt_st.tare = st_ff.comp;
                        end
                        if (lnk.wdata[B_SAVE] && st_ff.unlocked) begin
                            nxt_st.save = 1'b1;
                        end
                    end
                    REG_SPAN: begin
                        if (wr_cfg) begin
                            nxt_st.span = lnk.wdata;
                        end
                    end
                    REG_ZERO: begin
                        if (wr_cfg) begin
                            nxt_st.zero = lnk.wdata;
                        end
                    end
                    REG_DATE: begin
                        if (wr_cfg) begin
                            nxt_st.date = lnk.wdata;
                        end
                    end
                    REG_AVG: begin
                        if (wr_cfg) begin
                            nxt_st.avg = {16'h0000, lnk.wdata[15:0]};
                        end
                    end
                    REG_SCALE: begin
                        if (wr_cfg) begin
                            nxt_st.scale = lnk.wdata;
                        end
                    end
                    REG_UNIT: begin
                        if (wr_cfg) begin
                            nxt_st.unit = {24'h000000, lnk.wdata[7:0]};
                        end
                    end
                    REG_TARE: begin
                        if (wr_cfg) begin
                            nxt_st.tare = lnk.wdata;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (lnk.addr)
                    REG_STATUS: begin
                        nxt_st.rdata = st_ff.status;
                        nxt_st.rdata[B_WENB] = st_ff.unlocked;
                    end
                    REG_COMP: begin
                        nxt_st.rdata = st_ff.comp;
                        if (st_ff.status[B_AUTO] && !acq_done) begin
                            nxt_st.status[B_CONV] = 1'b0;
                        end
                    end
                    REG_MAX: nxt_st.rdata = range_max;
                    REG_MIN: nxt_st.rdata = range_min;
                    REG_SPAN: nxt_st.rdata = st_ff.span;
                    REG_ZERO: nxt_st.rdata = st_ff.zero;
                    REG_DATE: nxt_st.rdata = st_ff.date;
                    REG_AVG: nxt_st.rdata = st_ff.avg;
                    REG_SCALE: nxt_st.rdata = st_ff.scale;
                    REG_UNIT: nxt_st.rdata = st_ff.unit;
                    REG_TARE: nxt_st.rdata = st_ff.tare;
                    default: nxt_st.rdata = ZERO32;
                endcase
            end
        end
    end

    always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
        if (!lnk.presetn) begin
            st_ff <= '0;
            st_ff.avg <= AVG_RESET;
            st_ff.scale <= SCALE_RESET;
            st_ff.unit <= UNIT_RESET;
            st_ff.span <= SPAN_RESET;
            st_ff.status <= ONE32;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lnk.ack = st_ff.ack;
    assign lnk.rdata = st_ff.rdata;
    assign compensated_pressure = st_ff.comp;
    assign acquiring = st_ff.busy;
    assign nvm_save = st_ff.save;
    assign span_trim = st_ff.span;
    assign zero_trim = st_ff.zero;
endmodule : psc_sensor_regs

// ---- core/psc_host_ctrl.sv ----
// Host end: APB slave command registers driving the register link
module psc_host_ctrl
    import psc_pkg::*;
(
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Link
    psc_if.host lnk
);
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_ADDR = 8'h04;
    localparam logic [7:0] A_WDATA = 8'h08;
    localparam logic [7:0] A_RDATA = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;

    typedef enum logic [1:0] {
        psc_h_idle,
        psc_h_busy
    } psc_hstate_t;

    typedef struct packed {
        psc_hstate_t state;
        logic wr;
        logic [6:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic done;
    } psc_host_st_t;

    psc_host_st_t st_ff;
    psc_host_st_t nxt_st;
    logic acc;

    // Host writes are plain register transfers; trims computed by software
    always_comb begin
        nxt_st = st_ff;
        acc = psel && penable;
        case (st_ff.state)
            psc_h_idle: begin
                if (acc && pwrite && paddr[7:0] == A_CMD) begin
                    nxt_st.wr = pwdata[0];
                    nxt_st.done = 1'b0;
                    nxt_st.state = psc_h_busy;
                end
            end
            psc_h_busy: begin
                if (lnk.ack) begin
                    nxt_st.rdata = lnk.rdata;
                    nxt_st.done = 1'b1;
                    nxt_st.state = psc_h_idle;
                end
            end
            default: nxt_st.state = psc_h_idle;
        endcase
        if (acc && pwrite && st_ff.state == psc_h_idle) begin
            if (paddr[7:0] == A_ADDR) nxt_st.addr = pwdata[6:0];
            if (paddr[7:0] == A_WDATA) nxt_st.wdata = pwdata;
        end
    end

    always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
        if (!lnk.presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        case (paddr[7:0])
            A_ADDR: prdata = {25'h0, st_ff.addr};
            A_WDATA: prdata = st_ff.wdata;
            A_RDATA: prdata = st_ff.rdata;
            A_STAT: prdata = {30'h0, st_ff.state == psc_h_busy, st_ff.done};
            default: prdata = ZERO32;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign lnk.req = (st_ff.state == psc_h_busy) && !lnk.ack;
    assign lnk.wr = st_ff.wr;
    assign lnk.addr = st_ff.addr;
    assign lnk.wdata = st_ff.wdata;
endmodule : psc_host_ctrl

// ---- bench/psc_asserts.sv ----
// Link handshake and register checks for the host to sensor link
module psc_asserts
    import psc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic req,
    input wire logic wr,
    input wire logic [6:0] addr,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic unl_ff;
    logic [31:0] span_ff;
    logic [31:0] avg_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of lock state and two config registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_ff <= 1'b0;
            span_ff <= SPAN_RESET;
            avg_ff <= AVG_RESET;
        end else if (ack && wr) begin
            if (addr == REG_ACCESS)
                unl_ff <= wdata == ACCESS_KEY;
            if (addr == REG_SPAN && unl_ff)
                span_ff <= wdata;
            if (addr == REG_AVG && unl_ff)
                avg_ff <= wdata;
        end
    end
    sequence s_rd(logic [6:0] a);
        ack && !wr && addr == a;
    endsequence
    a_ack_follows_req: assert property (req && !ack |=> ack)
        else $error("ack missing after request");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_req_released: assert property (ack |=> !req)
        else $error("request not released after ack");
    a_req_held: assert property (req && !ack |=> $stable(addr)
        && $stable(wr) && $stable(wdata))
        else $error("request changed before ack");
    a_key_unlock: assert property (
        s_rd(REG_STATUS) |-> rdata[B_WENB] == unl_ff)
        else $error("unlock flag wrong");
    a_locked_span: assert property (
        s_rd(REG_SPAN) |-> rdata == span_ff)
        else $error("span trim content wrong");
    a_avg_fields: assert property (
        s_rd(REG_AVG) |-> rdata[15:0] == avg_ff[15:0])
        else $error("averaging fields wrong");
endmodule : psc_asserts

// ---- bench/testbench.sv ----
// Testbench joining host controller and sensor register set
module testbench import psc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, acq_tick;
    logic [31:0] paddr, pwdata, prdata, raw, cp, span, zero, q;
    logic acquiring, nvm_save;
    int fail_count, checks_done, cyc, acq_len, saves;
    logic [6:0] ra [6] = '{REG_SPAN, REG_ZERO, REG_DATE, REG_SCALE,
        REG_UNIT, REG_TARE};
    logic [31:0] rv [6] = '{32'h0001_8000, 32'h0000_0055, 32'h07df_0410,
        32'h0002_0000, 32'h0000_0006, 32'h0000_001e};
    psc_if i_psc_if (.pclk(pclk), .presetn(presetn));
    psc_host_ctrl i_psc_host_ctrl (.psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .lnk(i_psc_if));
    psc_sensor_regs i_psc_sensor_regs (.lnk(i_psc_if), .raw_pressure(raw),
        .range_max(32'h0000_03e8), .range_min(32'h0000_0000),
        .acq_tick(acq_tick), .compensated_pressure(cp),
        .acquiring(acquiring), .nvm_save(nvm_save), .span_trim(span),
        .zero_trim(zero));
    psc_asserts i_psc_asserts (.pclk(pclk), .presetn(presetn),
        .req(i_psc_if.req), .wr(i_psc_if.wr), .addr(i_psc_if.addr),
        .wdata(i_psc_if.wdata), .ack(i_psc_if.ack), .rdata(i_psc_if.rdata));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // Cycle count, acquisition length, save pulses, hang limit
    always @(posedge pclk) begin
        cyc++;
        if (acquiring === 1'b1) acq_len++;
        if (nvm_save === 1'b1) saves++;
        if (cyc == 20000) begin
            fail_count++;
            results;
        end
    end
    task automatic apb(input logic w, input logic [31:0] a, d,
        output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic lnk(input logic w, input logic [6:0] a,
        input logic [31:0] d);
        apb(1'b1, 32'h0000_0004, {25'h0, a}, q);
        apb(1'b1, 32'h0000_0008, d, q);
        apb(1'b1, 32'h0000_0000, {31'h0, w}, q);
        q = 32'h0000_0002;
        while (q[1:0] !== 2'b01) apb(1'b0, 32'h0000_0010, 32'h0, q);
        apb(1'b0, 32'h0000_000c, 32'h0, q);
    endtask : lnk
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        lnk(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [6:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffff_ffff);
        lnk(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rd
    task automatic idle;
        for (int i = 0; i < 3000 && acquiring !== 1'b0; i++) @(posedge pclk);
    endtask : idle
    task automatic run(input logic [31:0] s, input int n);
        acq_len = 0;
        wr(REG_STATUS, s);
        idle;
        chk(32'(acq_len), 32'(n));
    endtask : run
    task automatic tick;
        @(posedge pclk);
        acq_tick <= 1'b1;
        @(posedge pclk);
        acq_tick <= 1'b0;
    endtask : tick
    initial begin
        {psel, penable, pwrite, acq_tick} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        raw = 32'h0000_0064;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_AVG, AVG_RESET);
        rd(REG_SCALE, SCALE_RESET);
        rd(REG_UNIT, UNIT_RESET);
        wr(REG_SPAN, 32'h0000_1234);
        rd(REG_SPAN, SPAN_RESET);
        chk(32'(pslverr), 32'h0000_0000);
        wr(REG_ACCESS, ACCESS_KEY);
        rd(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
        foreach (ra[i]) wr(ra[i], rv[i]);
        foreach (ra[i]) rd(ra[i], rv[i]);
        chk(span, rv[0]);
        chk(zero, rv[1]);
        rd(REG_MAX, 32'h0000_03e8);
        rd(REG_MIN, 32'h0000_0000);
        wr(REG_AVG, 32'h0000_0000);
        rd(REG_AVG, 32'h0000_0000);
        run(32'h0000_0001, 2 * STEP_CYC + BASE_CYC);
        rd(REG_COMP, 32'h0000_00c8);
        chk(cp, 32'h0000_00c8);
        run(32'h0000_1001, 2 * STEP_CYC + BASE_CYC);
        rd(REG_COMP, 32'h0000_008c);
        wr(REG_STATUS, 32'h0000_1800);
        rd(REG_TARE, 32'h0000_008c);
        run(32'h0000_0201, INTL_CYC);
        rd(REG_COMP, 32'h0000_00c8);
        wr(REG_STATUS, 32'h0000_0100);
        tick;
        repeat (20) @(posedge pclk);
        tick;
        idle;
        rd(REG_STATUS, 32'h0000_0400, 32'h0000_0400);
        wr(REG_STATUS, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0000, 32'h0000_0400);
        wr(REG_STATUS, 32'h0000_0020);
        chk(32'(saves), 32'h0000_0001);
        wr(REG_ACCESS, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0000, 32'h0000_0008);
        wr(REG_UNIT, 32'h0000_0009);
        rd(REG_UNIT, 32'h0000_0006);
        results;
    end
endmodule : testbench
